/* File: rtl/dbw_pkg.sv */
// Purpose : constants and types of the debug breakpoint and watch unit
// Assumes : eight threads, four units of each breakpoint kind
// Notes   : offsets are processor status register numbers
package dbw_pkg;
   localparam logic [7:0]  REG_SAVED_PC    = 8'h11;
   localparam logic [7:0]  REG_SAVED_SP    = 8'h12;
   localparam logic [7:0]  REG_RD_THREAD   = 8'h13;
   localparam logic [7:0]  REG_RD_INDEX    = 8'h14;
   localparam logic [7:0]  REG_CAUSE       = 8'h15;
   localparam logic [7:0]  REG_EVENT_DATA  = 8'h16;
   localparam logic [7:0]  REG_HALT_MASK   = 8'h18;
   localparam logic [7:0]  REG_SCRATCH     = 8'h20;
   localparam logic [7:0]  REG_IB_ADDR     = 8'h30;
   localparam logic [7:0]  REG_IB_CTRL     = 8'h40;
   localparam logic [7:0]  REG_DW_ADDR_A   = 8'h50;
   localparam logic [7:0]  REG_DW_ADDR_B   = 8'h60;
   localparam logic [7:0]  REG_DW_CTRL     = 8'h70;
   localparam logic [7:0]  REG_RW_MASK     = 8'h80;
   localparam logic [7:0]  REG_RW_VALUE    = 8'h90;
   localparam logic [7:0]  REG_RW_CTRL     = 8'h9c;
   localparam int          CTRL_EN_BIT     = 0;
   localparam int          CTRL_MODE_BIT   = 1;
   localparam int          CTRL_LOAD_BIT   = 2;
   localparam int          CTRL_TMASK_LSB  = 16;
   localparam int          CAUSE_IDX_LSB   = 16;
   localparam int          CAUSE_THR_LSB   = 8;
   localparam logic [2:0]  CAUSE_NONE      = 3'h0;
   localparam logic [2:0]  CAUSE_HOST      = 3'h1;
   localparam logic [2:0]  CAUSE_CALL      = 3'h2;
   localparam logic [2:0]  CAUSE_INSTR     = 3'h3;
   localparam logic [2:0]  CAUSE_DATA      = 3'h4;
   localparam logic [2:0]  CAUSE_RES       = 3'h5;
   localparam logic [31:0] WORD_RESET      = 32'h0;
   localparam logic [7:0]  BYTE_RESET      = 8'h0;

   typedef enum logic [1:0] {
      DBW_RUN   = 2'b01,
      DBW_DEBUG = 2'b10
   } dbw_mode_t;

   typedef struct packed {
      dbw_mode_t        mode;
      logic [31:0]      saved_pc;
      logic [31:0]      saved_sp;
      logic [7:0]       rd_thread;
      logic [4:0]       rd_index;
      logic [2:0]       cause;
      logic [1:0]       cause_idx;
      logic [7:0]       cause_thr;
      logic [31:0]      event_data;
      logic [7:0]       halt_mask;
      logic [7:0][31:0] scratch;
      logic [3:0][31:0] ib_addr;
      logic [3:0][1:0]  ib_ctrl;
      logic [3:0][7:0]  ib_tmask;
      logic [3:0][31:0] dw_addr_a;
      logic [3:0][31:0] dw_addr_b;
      logic [3:0][2:0]  dw_ctrl;
      logic [3:0][7:0]  dw_tmask;
      logic [3:0][31:0] rw_mask;
      logic [3:0][31:0] rw_value;
      logic [3:0][1:0]  rw_ctrl;
      logic [3:0][7:0]  rw_tmask;
      logic [31:0]      ps_rdata;
      logic [31:0]      cfg_rdata;
      logic             enter;
   } dbw_state_t;
endpackage : dbw_pkg

/* File: rtl/dbw_unit.sv */
// Purpose : debug breakpoint and watch unit of a multithreaded tile
// Assumes : pipeline and debugger inputs synchronous to core_clk_i
// Notes   : status registers writable only while in debug mode, except scratch through the config port
`timescale 1ns/100ps
module dbw_unit
   import dbw_pkg::*;
#(
   parameter int NUM_THREADS = 8
) (
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   // processor status register port
   input  wire logic [7:0]  ps_addr_i,
   input  wire logic        ps_rd_i,
   input  wire logic        ps_wr_i,
   input  wire logic [31:0] ps_wdata_i,
   output logic [31:0]      ps_rdata_o,
   // tile configuration scratch port
   input  wire logic [2:0]  cfg_idx_i,
   input  wire logic        cfg_rd_i,
   input  wire logic        cfg_wr_i,
   input  wire logic [31:0] cfg_wdata_i,
   output logic [31:0]      cfg_rdata_o,
   // debug event sources
   input  wire logic        host_req_i,
   input  wire logic        call_valid_i,
   input  wire logic [7:0]  call_thread_i,
   input  wire logic        instr_valid_i,
   input  wire logic [31:0] instr_pc_i,
   input  wire logic [7:0]  instr_thread_i,
   input  wire logic        mem_valid_i,
   input  wire logic        mem_load_i,
   input  wire logic [31:0] mem_addr_i,
   input  wire logic [7:0]  mem_thread_i,
   input  wire logic        res_valid_i,
   input  wire logic [31:0] res_id_i,
   input  wire logic [7:0]  res_thread_i,
   // context of the interrupted thread
   input  wire logic [31:0] saved_program_counter_i,
   input  wire logic [31:0] saved_stack_pointer_i,
   input  wire logic        debug_return_i,
   // to pipeline and scheduler
   output logic             debug_enter_o,
   output logic             debug_mode_o,
   output logic [7:0]       reg_read_thread_o,
   output logic [4:0]       reg_read_index_o,
   output logic [7:0]       thread_halt_o
);

   dbw_state_t st_ff;
   dbw_state_t nxt_st;

   logic [3:0] ib_hit;
   logic [3:0] dw_hit;
   logic [3:0] rw_hit;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [1:0] lowest_idx(input logic [3:0] v);
      logic [1:0] r;
      r = 2'h0;
      for (int k = 3; k >= 0; k--) begin
         if (v[k]) begin
            r = 2'(k);
         end
      end
      return r;
   endfunction : lowest_idx

   function automatic logic thread_on(input logic [7:0] tmask, input logic [7:0] thr);
      logic r;
      r = 1'b0;
      if (thr < 8'(NUM_THREADS)) begin
         r = tmask[thr[2:0]];
      end
      return r;
   endfunction : thread_on

   // ----------------------------------------------------------------
   // match logic
   // ----------------------------------------------------------------
   for (genvar g = 0; g < 4; g++) begin : g_match
      logic pc_eq;
      logic cond_a;
      logic cond_b;
      logic dw_cond;
      logic rs_eq;
      assign pc_eq   = (instr_pc_i == st_ff.ib_addr[g]);
      assign ib_hit[g] = instr_valid_i && st_ff.ib_ctrl[g][CTRL_EN_BIT]
                         && thread_on(st_ff.ib_tmask[g], instr_thread_i)
                         && (st_ff.ib_ctrl[g][CTRL_MODE_BIT] ? !pc_eq : pc_eq);
      assign cond_a  = (mem_addr_i >= st_ff.dw_addr_a[g]);
      assign cond_b  = (mem_addr_i <= st_ff.dw_addr_b[g]);
      assign dw_cond = st_ff.dw_ctrl[g][CTRL_MODE_BIT] ? (cond_a || cond_b) : (cond_a && cond_b);
      assign dw_hit[g] = mem_valid_i && st_ff.dw_ctrl[g][CTRL_EN_BIT]
                         && (!mem_load_i || st_ff.dw_ctrl[g][CTRL_LOAD_BIT])
                         && thread_on(st_ff.dw_tmask[g], mem_thread_i)
                         && dw_cond;
      assign rs_eq   = ((res_id_i & st_ff.rw_mask[g]) == st_ff.rw_value[g]);
      assign rw_hit[g] = res_valid_i && st_ff.rw_ctrl[g][CTRL_EN_BIT]
                         && thread_on(st_ff.rw_tmask[g], res_thread_i)
                         && (st_ff.rw_ctrl[g][CTRL_MODE_BIT] ? !rs_eq : rs_eq);
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic       ev;
      logic       dbg_wr;
      logic [1:0] sub;
      ev     = 1'b0;
      dbg_wr = 1'b0;
      sub    = ps_addr_i[1:0];
      nxt_st = st_ff;
      nxt_st.enter = 1'b0;
      dbg_wr = ps_wr_i && (st_ff.mode == DBW_DEBUG);

      // software writes first, entry capture overrides
      if (dbg_wr) begin
         case (ps_addr_i)
            REG_SAVED_PC:   nxt_st.saved_pc   = ps_wdata_i;
            REG_SAVED_SP:   nxt_st.saved_sp   = ps_wdata_i;
            REG_RD_THREAD:  nxt_st.rd_thread  = ps_wdata_i[7:0];
            REG_RD_INDEX:   nxt_st.rd_index   = ps_wdata_i[4:0];
            REG_CAUSE: begin
               nxt_st.cause     = ps_wdata_i[2:0];
               nxt_st.cause_thr = ps_wdata_i[CAUSE_THR_LSB +: 8];
               nxt_st.cause_idx = ps_wdata_i[CAUSE_IDX_LSB +: 2];
            end
            REG_EVENT_DATA: nxt_st.event_data = ps_wdata_i;
            REG_HALT_MASK:  nxt_st.halt_mask  = ps_wdata_i[7:0];
            default: begin
               case (ps_addr_i[7:2])
                  REG_IB_ADDR[7:2]:   nxt_st.ib_addr[sub]   = ps_wdata_i;
                  REG_IB_CTRL[7:2]: begin
                     nxt_st.ib_ctrl[sub]  = ps_wdata_i[1:0];
                     nxt_st.ib_tmask[sub] = ps_wdata_i[CTRL_TMASK_LSB +: 8];
                  end
                  REG_DW_ADDR_A[7:2]: nxt_st.dw_addr_a[sub] = ps_wdata_i;
                  REG_DW_ADDR_B[7:2]: nxt_st.dw_addr_b[sub] = ps_wdata_i;
                  REG_DW_CTRL[7:2]: begin
                     nxt_st.dw_ctrl[sub]  = ps_wdata_i[2:0];
                     nxt_st.dw_tmask[sub] = ps_wdata_i[CTRL_TMASK_LSB +: 8];
                  end
                  REG_RW_MASK[7:2]:   nxt_st.rw_mask[sub]   = ps_wdata_i;
                  REG_RW_VALUE[7:2]:  nxt_st.rw_value[sub]  = ps_wdata_i;
                  REG_RW_CTRL[7:2]: begin
                     nxt_st.rw_ctrl[sub]  = ps_wdata_i[1:0];
                     nxt_st.rw_tmask[sub] = ps_wdata_i[CTRL_TMASK_LSB +: 8];
                  end
                  default: begin
                     if (ps_addr_i[7:3] == REG_SCRATCH[7:3]) begin
                        nxt_st.scratch[ps_addr_i[2:0]] = ps_wdata_i;
                     end
                  end
               endcase
            end
         endcase
      end
      if (cfg_wr_i && !(dbg_wr && ps_addr_i[7:3] == REG_SCRATCH[7:3] && ps_addr_i[2:0] == cfg_idx_i)) begin
         nxt_st.scratch[cfg_idx_i] = cfg_wdata_i;
      end

      // debug entry, fixed cause priority
      case (st_ff.mode)
         DBW_RUN: begin
            ev = host_req_i || call_valid_i || (|ib_hit) || (|dw_hit) || (|rw_hit);
            if (ev) begin
               nxt_st.mode     = DBW_DEBUG;
               nxt_st.enter    = 1'b1;
               nxt_st.saved_pc = saved_program_counter_i;
               nxt_st.saved_sp = saved_stack_pointer_i;
               nxt_st.cause_idx = 2'h0;
               if (host_req_i) begin
                  nxt_st.cause     = CAUSE_HOST;
                  nxt_st.cause_thr = BYTE_RESET;
               end else if (call_valid_i) begin
                  nxt_st.cause     = CAUSE_CALL;
                  nxt_st.cause_thr = call_thread_i;
               end else if (|ib_hit) begin
                  nxt_st.cause     = CAUSE_INSTR;
                  nxt_st.cause_thr = instr_thread_i;
                  nxt_st.cause_idx = lowest_idx(ib_hit);
               end else if (|dw_hit) begin
                  nxt_st.cause      = CAUSE_DATA;
                  nxt_st.cause_thr  = mem_thread_i;
                  nxt_st.cause_idx  = lowest_idx(dw_hit);
                  nxt_st.event_data = mem_addr_i;
               end else begin
                  nxt_st.cause      = CAUSE_RES;
                  nxt_st.cause_thr  = res_thread_i;
                  nxt_st.cause_idx  = lowest_idx(rw_hit);
                  nxt_st.event_data = res_id_i;
               end
            end
         end
         DBW_DEBUG: begin
            if (debug_return_i) begin
               nxt_st.mode = DBW_RUN;
            end
         end
         default: begin
            nxt_st.mode = DBW_RUN;
         end
      endcase

      // registered read data
      nxt_st.ps_rdata = WORD_RESET;
      if (ps_rd_i) begin
         case (ps_addr_i)
            REG_SAVED_PC:   nxt_st.ps_rdata = st_ff.saved_pc;
            REG_SAVED_SP:   nxt_st.ps_rdata = st_ff.saved_sp;
            REG_RD_THREAD:  nxt_st.ps_rdata = {24'h0, st_ff.rd_thread};
            REG_RD_INDEX:   nxt_st.ps_rdata = {27'h0, st_ff.rd_index};
            REG_CAUSE:      nxt_st.ps_rdata = {14'h0, st_ff.cause_idx, st_ff.cause_thr, 5'h0, st_ff.cause};
            REG_EVENT_DATA: nxt_st.ps_rdata = st_ff.event_data;
            REG_HALT_MASK:  nxt_st.ps_rdata = {24'h0, st_ff.halt_mask};
            default: begin
               case (ps_addr_i[7:2])
                  REG_IB_ADDR[7:2]:   nxt_st.ps_rdata = st_ff.ib_addr[sub];
                  REG_IB_CTRL[7:2]:   nxt_st.ps_rdata = {8'h0, st_ff.ib_tmask[sub], 14'h0, st_ff.ib_ctrl[sub]};
                  REG_DW_ADDR_A[7:2]: nxt_st.ps_rdata = st_ff.dw_addr_a[sub];
                  REG_DW_ADDR_B[7:2]: nxt_st.ps_rdata = st_ff.dw_addr_b[sub];
                  REG_DW_CTRL[7:2]:   nxt_st.ps_rdata = {8'h0, st_ff.dw_tmask[sub], 13'h0, st_ff.dw_ctrl[sub]};
                  REG_RW_MASK[7:2]:   nxt_st.ps_rdata = st_ff.rw_mask[sub];
                  REG_RW_VALUE[7:2]:  nxt_st.ps_rdata = st_ff.rw_value[sub];
                  REG_RW_CTRL[7:2]:   nxt_st.ps_rdata = {8'h0, st_ff.rw_tmask[sub], 14'h0, st_ff.rw_ctrl[sub]};
                  default: begin
                     if (ps_addr_i[7:3] == REG_SCRATCH[7:3]) begin
                        nxt_st.ps_rdata = st_ff.scratch[ps_addr_i[2:0]];
                     end
                  end
               endcase
            end
         endcase
      end
      nxt_st.cfg_rdata = cfg_rd_i ? st_ff.scratch[cfg_idx_i] : WORD_RESET;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_ff      <= '0;
         st_ff.mode <= DBW_RUN;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign ps_rdata_o        = st_ff.ps_rdata;
   assign cfg_rdata_o       = st_ff.cfg_rdata;
   assign debug_enter_o     = st_ff.enter;
   assign debug_mode_o      = (st_ff.mode == DBW_DEBUG);
   assign reg_read_thread_o = st_ff.rd_thread;
   assign reg_read_index_o  = st_ff.rd_index;
   assign thread_halt_o     = (st_ff.mode == DBW_RUN) ? st_ff.halt_mask : 8'h00;

endmodule : dbw_unit

/* File: sim/dbw_unit_checker.sv */
// Purpose : port checks of the debug breakpoint and watch unit
// Assumes : one clock, asynchronous active-high reset
// Notes   : bound into every dbw_unit
`timescale 1ns/100ps
module dbw_unit_checker
   import dbw_pkg::*;
(
   input wire logic        core_clk_i,
   input wire logic        rst_i,
   input wire logic [7:0]  ps_addr_i,
   input wire logic        ps_rd_i,
   input wire logic        ps_wr_i,
   input wire logic [31:0] ps_rdata_o,
   input wire logic        host_req_i,
   input wire logic        call_valid_i,
   input wire logic        instr_valid_i,
   input wire logic        mem_valid_i,
   input wire logic        res_valid_i,
   input wire logic        debug_return_i,
   input wire logic        debug_enter_o,
   input wire logic        debug_mode_o,
   input wire logic [7:0]  reg_read_thread_o,
   input wire logic [4:0]  reg_read_index_o,
   input wire logic [7:0]  thread_halt_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_idle_run;
      !debug_mode_o && !host_req_i && !call_valid_i && !instr_valid_i && !mem_valid_i && !res_valid_i;
   endsequence
   sequence s_entry;
      debug_enter_o && debug_mode_o ##1 !debug_enter_o;
   endsequence
   chk_host_entry: assert property (!debug_mode_o && host_req_i |=> s_entry)
      else $error("host request did not enter debug mode");
   chk_quiet_run: assert property (s_idle_run |=> !debug_enter_o)
      else $error("debug entry without an event");
   chk_debug_hold: assert property (debug_mode_o && !debug_return_i |=> debug_mode_o && !debug_enter_o)
      else $error("debug mode left or re-entered without return");
   chk_return_exit: assert property (debug_mode_o && debug_return_i |=> !debug_mode_o)
      else $error("debug mode kept after return");
   chk_halt_debug: assert property (debug_mode_o |-> thread_halt_o == 8'h0)
      else $error("threads halted while in debug mode");
   chk_entry_pulse: assert property ($rose(debug_mode_o) |-> debug_enter_o)
      else $error("debug mode rose without entry pulse");
   chk_rd_idle: assert property (!ps_rd_i |=> ps_rdata_o == 32'h0)
      else $error("read data not zero when idle");
   chk_thread_read: assert property (ps_rd_i && !ps_wr_i && ps_addr_i == REG_RD_THREAD
      |=> ps_rdata_o == {24'h0, $past(reg_read_thread_o)}) else $error("thread select read mismatch");
   chk_index_read: assert property (ps_rd_i && !ps_wr_i && ps_addr_i == REG_RD_INDEX
      |=> ps_rdata_o == {27'h0, $past(reg_read_index_o)}) else $error("index select read mismatch");
endmodule : dbw_unit_checker

bind dbw_unit dbw_unit_checker u_dbw_unit_checker (.core_clk_i(core_clk_i), .rst_i(rst_i),
   .ps_addr_i(ps_addr_i), .ps_rd_i(ps_rd_i), .ps_wr_i(ps_wr_i), .ps_rdata_o(ps_rdata_o),
   .host_req_i(host_req_i), .call_valid_i(call_valid_i), .instr_valid_i(instr_valid_i),
   .mem_valid_i(mem_valid_i), .res_valid_i(res_valid_i), .debug_return_i(debug_return_i),
   .debug_enter_o(debug_enter_o), .debug_mode_o(debug_mode_o), .reg_read_thread_o(reg_read_thread_o),
   .reg_read_index_o(reg_read_index_o), .thread_halt_o(thread_halt_o));

/* File: sim/dbw_pipe_model.sv */
// Purpose : pipeline and debugger side that raises debug events
// Assumes : one event per call, context stable over the event edge
// Notes   : after an event, thread and value fields show the inverse of their last value
`timescale 1ns/100ps
module dbw_pipe_model
   import dbw_pkg::*;
(
   input  wire logic        core_clk_i,
   output logic [4:0]       event_o,
   output logic             load_o,
   output logic [7:0]       thread_o,
   output logic [31:0]      value_o,
   output logic [31:0]      pc_o,
   output logic [31:0]      sp_o,
   output logic             return_o
);
   initial begin
      {event_o, load_o, return_o} = '0;
      {thread_o, value_o, pc_o, sp_o} = '0;
   end
   // one-cycle event strobe, bit per cause code
   task automatic fire(input logic [2:0] kind, input logic [7:0] thr, input logic [31:0] val,
                       input logic ld, input logic [31:0] pc, input logic [31:0] sp);
      thread_o <= thr;
      value_o  <= val;
      load_o   <= ld;
      pc_o     <= pc;
      sp_o     <= sp;
      event_o  <= 5'h1 << (kind - 3'h1);
      @(posedge core_clk_i);
      event_o  <= 5'h0;
      thread_o <= ~thr;
      value_o  <= ~val;
   endtask : fire
   task automatic leave;
      return_o <= 1'b1;
      @(posedge core_clk_i);
      return_o <= 1'b0;
   endtask : leave
endmodule : dbw_pipe_model

/* File: sim/tb_debug_breakpoint_watch_unit.sv */
// Purpose : self-checking bench of the debug breakpoint and watch unit
// Assumes : design answers reads one cycle after the read edge
// Notes   : random scratch and context values from a fixed lfsr seed
`timescale 1ns/100ps
module tb_debug_breakpoint_watch_unit;
   import dbw_pkg::*;
   logic        core_clk_i, rst_i, ps_rd, ps_wr, cfg_rd, cfg_wr, ld, ret, enter, dmode;
   logic [7:0]  ps_addr, thr, halt, rthr;
   logic [2:0]  cfg_idx;
   logic [4:0]  evt, ridx;
   logic [31:0] ps_wdata, cfg_wdata, rnd, ps_rdata, cfg_rdata, val, pc, sp;
   logic [31:0] exp_s [8];
   int          n_fail, samples_checked;
   localparam logic [7:0] RST_REGS [6] = '{REG_CAUSE, REG_IB_CTRL, REG_DW_CTRL, REG_RW_CTRL, REG_RW_CTRL + 8'h3,
                                          REG_HALT_MASK};
   dbw_unit u_dbw_unit (.core_clk_i(core_clk_i), .rst_i(rst_i), .ps_addr_i(ps_addr), .ps_rd_i(ps_rd),
      .ps_wr_i(ps_wr), .ps_wdata_i(ps_wdata), .ps_rdata_o(ps_rdata), .cfg_idx_i(cfg_idx), .cfg_rd_i(cfg_rd),
      .cfg_wr_i(cfg_wr), .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(cfg_rdata), .host_req_i(evt[0]),
      .call_valid_i(evt[1]), .call_thread_i(thr), .instr_valid_i(evt[2]), .instr_pc_i(val),
      .instr_thread_i(thr), .mem_valid_i(evt[3]), .mem_load_i(ld), .mem_addr_i(val), .mem_thread_i(thr),
      .res_valid_i(evt[4]), .res_id_i(val), .res_thread_i(thr), .saved_program_counter_i(pc),
      .saved_stack_pointer_i(sp), .debug_return_i(ret), .debug_enter_o(enter), .debug_mode_o(dmode),
      .reg_read_thread_o(rthr), .reg_read_index_o(ridx), .thread_halt_o(halt));
   dbw_pipe_model u_dbw_pipe_model (.core_clk_i(core_clk_i), .event_o(evt), .load_o(ld), .thread_o(thr),
      .value_o(val), .pc_o(pc), .sp_o(sp), .return_o(ret));
   initial begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   function automatic logic [31:0] cause_word(input logic [2:0] c, input logic [1:0] i, input logic [7:0] t);
      return {14'h0, i, t, 5'h0, c};
   endfunction : cause_word
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic close_out;
      if (n_fail == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ps_addr  <= a;
      ps_wdata <= d;
      ps_wr    <= 1'b1;
      @(posedge core_clk_i);
      ps_wr    <= 1'b0;
      @(posedge core_clk_i);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
      ps_addr <= a;
      ps_rd   <= 1'b1;
      @(posedge core_clk_i);
      ps_rd   <= 1'b0;
      #1 cmp(what, e, ps_rdata);
      @(posedge core_clk_i);
   endtask : rd
   task automatic crd(input logic [2:0] i, input logic [31:0] e);
      cfg_idx <= i;
      cfg_rd  <= 1'b1;
      @(posedge core_clk_i);
      cfg_rd  <= 1'b0;
      #1 cmp("scratch via config view", e, cfg_rdata);
      @(posedge core_clk_i);
   endtask : crd
   // leaves debug mode first, then one event and its capture
   task automatic ev(input logic [2:0] k, input logic [7:0] t, input logic [31:0] v, input logic l,
                     input logic hit, input logic [1:0] idx);
      logic [31:0] p;
      logic [31:0] s;
      if (dmode === 1'b1) u_dbw_pipe_model.leave();
      rnd = lfsr(rnd);
      p = rnd;
      rnd = lfsr(rnd);
      s = rnd;
      u_dbw_pipe_model.fire(k, t, v, l, p, s);
      #1 cmp("entry pulse", {31'h0, hit}, {31'h0, enter});
      if (hit) begin
         rd(REG_CAUSE, cause_word(k, idx, (k == CAUSE_HOST) ? 8'h0 : t), "cause");
         if (k >= CAUSE_DATA) rd(REG_EVENT_DATA, v, "event data");
         rd(REG_SAVED_PC, p, "saved pc");
         rd(REG_SAVED_SP, s, "saved sp");
      end else begin
         @(posedge core_clk_i);
      end
   endtask : ev
   initial begin
      {ps_rd, ps_wr, cfg_rd, cfg_wr, ps_addr, cfg_idx, ps_wdata, cfg_wdata} = '0;
      n_fail = 0;
      samples_checked = 0;
      rnd = 32'h41ba5377;
      rst_i = 1'b1;
      repeat (2) @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(posedge core_clk_i);
      foreach (RST_REGS[i]) rd(RST_REGS[i], 32'h0, "reset value");
      wr(REG_IB_ADDR, 32'hffffffff);
      rd(REG_IB_ADDR, 32'h0, "write outside debug");
      ev(CAUSE_HOST, 8'h07, 32'h0, 1'b0, 1'b1, 2'h0);
      wr(REG_RD_THREAD, 32'hffffffff);
      rd(REG_RD_THREAD, 32'h000000ff, "thread select");
      wr(REG_RD_INDEX, 32'hffffffff);
      rd(REG_RD_INDEX, 32'h0000001f, "index select");
      wr(REG_SAVED_PC, 32'h1234abcd);
      rd(REG_SAVED_PC, 32'h1234abcd, "saved pc rewrite");
      wr(REG_EVENT_DATA, 32'h5a5a0f0f);
      rd(REG_EVENT_DATA, 32'h5a5a0f0f, "event data rewrite");
      wr(REG_CAUSE, 32'hffffffff);
      rd(REG_CAUSE, 32'h0003ff07, "cause rewrite");
      rd(8'h17, 32'h0, "unmapped read");
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         exp_s[i] = rnd;
         wr(REG_SCRATCH + 8'(i), rnd);
      end
      for (int i = 0; i < 8; i++) crd(3'(i), exp_s[i]);
      cfg_idx   <= 3'h5;
      cfg_wdata <= ~exp_s[5];
      cfg_wr    <= 1'b1;
      @(posedge core_clk_i);
      cfg_wr    <= 1'b0;
      rd(REG_SCRATCH + 8'h5, ~exp_s[5], "scratch via status view");
      wr(REG_IB_ADDR, 32'h00004000);
      wr(REG_IB_ADDR + 8'h1, 32'h00004000);
      wr(REG_IB_ADDR + 8'h2, 32'h00005000);
      wr(REG_IB_CTRL, 32'h00040001);
      wr(REG_IB_CTRL + 8'h1, 32'h00ff0001);
      wr(REG_IB_CTRL + 8'h2, 32'hffffffff);
      rd(REG_IB_CTRL + 8'h2, 32'h00ff0003, "instr control");
      wr(REG_DW_ADDR_A, 32'h00000100);
      wr(REG_DW_ADDR_B, 32'h000001ff);
      wr(REG_DW_CTRL, 32'h00ff0001);
      wr(REG_DW_ADDR_A + 8'h1, 32'h00000800);
      wr(REG_DW_ADDR_B + 8'h1, 32'h00000010);
      wr(REG_DW_CTRL + 8'h1, 32'h00ff0003);
      wr(REG_RW_MASK, 32'h000000ff);
      wr(REG_RW_VALUE, 32'h00000042);
      wr(REG_RW_CTRL, 32'h00ff0001);
      ev(CAUSE_INSTR, 8'h02, 32'h00004000, 1'b0, 1'b1, 2'h0);
      ev(CAUSE_INSTR, 8'h03, 32'h00004000, 1'b0, 1'b1, 2'h1);
      ev(CAUSE_INSTR, 8'h05, 32'h00006000, 1'b0, 1'b1, 2'h2);
      ev(CAUSE_INSTR, 8'h05, 32'h00005000, 1'b0, 1'b0, 2'h0);
      ev(CAUSE_DATA, 8'h01, 32'h00000150, 1'b0, 1'b1, 2'h0);
      ev(CAUSE_DATA, 8'h01, 32'h00000150, 1'b1, 1'b0, 2'h0);
      ev(CAUSE_DATA, 8'h06, 32'h00000900, 1'b0, 1'b1, 2'h1);
      ev(CAUSE_DATA, 8'h06, 32'h00000200, 1'b0, 1'b0, 2'h0);
      ev(CAUSE_RES, 8'h04, 32'h00001242, 1'b0, 1'b1, 2'h0);
      ev(CAUSE_RES, 8'h04, 32'h00001243, 1'b0, 1'b0, 2'h0);
      ev(CAUSE_CALL, 8'h06, 32'h0, 1'b0, 1'b1, 2'h0);
      wr(REG_RW_CTRL, 32'h00ff0003);
      wr(REG_HALT_MASK, 32'h00000005);
      ev(CAUSE_RES, 8'h04, 32'h00001242, 1'b0, 1'b0, 2'h0);
      cmp("halted threads", 32'h00000005, {24'h0, halt});
      ev(CAUSE_RES, 8'h04, 32'h00001243, 1'b0, 1'b1, 2'h0);
      close_out();
   end
   initial begin
      repeat (5000) @(posedge core_clk_i);
      n_fail++;
      close_out();
   end
endmodule : tb_debug_breakpoint_watch_unit
